// ===== asfc_alu.sv
// ALU status flag control: temporary operands, arithmetic, logic, evaluation
// and rotation, flag update, write-back and skip decisions.
// Assumes the sequencer holds exec for one cycle per instruction and an
// AHB-Lite master with a single slave on hclk.
// Operation
// - Compare flag set: arithmetic updates flags but writes no result.
// - Decimal flag set: arithmetic in single-digit BCD, else 4-bit binary.
// - Compare flag clear: zero flag set on zero result, else cleared.
// - Compare flag set: zero result keeps zero flag, nonzero clears it.
// - Only arithmetic or status word writes change the zero flag.
// - Arithmetic sets carry on carry or borrow, else clears it.
// - With-carry instructions feed the carry flag in as carry input.
// - Rotate: carry into b3, shift right, old b0 into carry.
// - Carry changes only by arithmetic, rotation and status word writes.
// - Bit evaluation clears the compare flag.
// - Compare flag does not affect comparisons, logic or rotation.
// - Decimal flag does not affect logic, evaluations or rotation.
// - Status word flags and ALU flags are the same flip-flops.
// - Operands are latched in 4-bit temporary registers A and B first.
// - Logic keeps zero and carry, ignores mode flags, always stores.
// - Evaluations only decide a skip of the next instruction, no store.
// - BCD add of 20 up, or sub outside -10..9, stores 1010B or more.
`timescale 1ns/1ns
`default_nettype none

module asfc_alu
   import asfc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic exec,
   input wire asfc_op_type op,
   input wire logic dest_is_reg,
   input wire logic [3:0] first_operand,
   input wire logic [3:0] second_operand,
   output logic busy,
   output logic done,
   output logic [3:0] result,
   output logic reg_write,
   output logic mem_write,
   output logic skip_next,
   output logic zero_flag,
   output logic carry_flag,
   output logic compare_no_store_flag,
   output logic decimal_flag
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [3:0] psw_reg;
   logic [3:0] temp_a_reg;
   logic [3:0] temp_b_reg;
   asfc_op_type op_reg;
   logic dest_reg;
   logic pend_reg;
   logic done_reg;
   logic [3:0] result_reg;
   logic reg_wr_reg;
   logic mem_wr_reg;
   logic skip_reg;
   logic dp_write_reg;
   logic dp_read_reg;
   logic [ASFC_ADDR_BITS-1:0] dp_addr_reg;

   logic is_arith;
   logic is_sub;
   logic cin;
   logic [5:0] bin_wide;
   logic [3:0] arith_val;
   logic arith_cy;
   logic [3:0] alu_val;
   logic eval_skip;
   logic [3:0] psw_next;
   logic [5:0] adj;

   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------

   // The slave never stalls and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase capture of accepted transfers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_reg <= 1'b0;
         dp_read_reg <= 1'b0;
         dp_addr_reg <= '0;
      end else if (hready) begin
         dp_write_reg <= hsel & htrans[1] & hwrite;
         dp_read_reg <= hsel & htrans[1] & ~hwrite;
         dp_addr_reg <= haddr[ASFC_ADDR_BITS-1:0];
      end
   end

   // Read data during the data phase; unmapped words read as zero.
   always_comb begin
      hrdata = '0;
      if (dp_read_reg) begin
         if (dp_addr_reg == ASFC_PSW_OFFSET) begin
            hrdata[3:0] = psw_reg;
         end else if (dp_addr_reg == ASFC_TEMP_OFFSET) begin
            hrdata[ASFC_TEMP_B_LSB+3:0] = {temp_b_reg, temp_a_reg};
         end
      end
   end

   // -----------------------------------------------------------------
   // Operand latch
   // -----------------------------------------------------------------

   // Operands go to temporary registers A and B when exec is taken.
   // A second exec while busy is ignored, so the operands never change under
   // the operation that is being computed.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         temp_a_reg <= ASFC_NIBBLE_ZERO;
         temp_b_reg <= ASFC_NIBBLE_ZERO;
         op_reg <= ASFC_OP_ADD;
         dest_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         pend_reg <= exec & ~pend_reg;
         if (exec && !pend_reg) begin
            temp_a_reg <= first_operand;
            temp_b_reg <= second_operand;
            op_reg <= op;
            dest_reg <= dest_is_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // Arithmetic
   // -----------------------------------------------------------------

   // Binary sum or difference with optional carry or borrow input.
   always_comb begin
      is_arith = (op_reg == ASFC_OP_ADD) || (op_reg == ASFC_OP_ADDC) ||
                 (op_reg == ASFC_OP_SUB) || (op_reg == ASFC_OP_SUBC);
      is_sub = (op_reg == ASFC_OP_SUB) || (op_reg == ASFC_OP_SUBC);
      cin = ((op_reg == ASFC_OP_ADDC) || (op_reg == ASFC_OP_SUBC)) &
            psw_reg[ASFC_CARRY_BIT];
      if (is_sub) begin
         bin_wide = {2'b00, temp_a_reg} - {2'b00, temp_b_reg} - {5'b00000, cin};
      end else begin
         bin_wide = {2'b00, temp_a_reg} + {2'b00, temp_b_reg} + {5'b00000, cin};
      end
   end

   // Result and carry in binary or BCD, by the decimal flag.
   // Out-of-range decimal outcomes keep the low two bits of an offset value
   // and set the upper two bits to 11B, or 10B for sums of 28 and 29, so they always read as 1010B or above.
   always_comb begin
      adj = 6'h00;
      arith_val = bin_wide[3:0];
      arith_cy = bin_wide[4];
      if (psw_reg[ASFC_DEC_BIT]) begin
         if (!is_sub) begin
            arith_cy = bin_wide >= ASFC_BCD_TEN;
            adj = bin_wide + ASFC_BCD_TWO;
            if (bin_wide >= ASFC_BCD_TWENTY) begin
               if (bin_wide == ASFC_BCD_28 || bin_wide == ASFC_BCD_29) begin
                  arith_val = {ASFC_HI_MID, adj[1:0]};
               end else begin
                  arith_val = {ASFC_HI_TOP, adj[1:0]};
               end
            end else if (arith_cy) begin
               adj = bin_wide - ASFC_BCD_TEN;
               arith_val = adj[3:0];
            end
         end else begin
            arith_cy = bin_wide[5] || (bin_wide >= ASFC_BCD_TEN);
            if (bin_wide[5] && bin_wide >= ASFC_BCD_SUB_LOW) begin
               adj = bin_wide + ASFC_BCD_TEN;
               arith_val = adj[3:0];
            end else if (arith_cy) begin
               adj = bin_wide - ASFC_BCD_TEN;
               arith_val = {ASFC_HI_TOP, adj[1:0]};
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Logic, evaluation and rotation
   // -----------------------------------------------------------------

   // Non-arithmetic classes work on plain binary, ignoring mode flags.
   always_comb begin
      alu_val = arith_val;
      eval_skip = 1'b0;
      unique case (op_reg)
         ASFC_OP_OR: alu_val = temp_a_reg | temp_b_reg;
         ASFC_OP_AND: alu_val = temp_a_reg & temp_b_reg;
         ASFC_OP_XOR: alu_val = temp_a_reg ^ temp_b_reg;
         ASFC_OP_SKT: eval_skip = (temp_a_reg & temp_b_reg) == temp_b_reg;
         ASFC_OP_SKF: eval_skip = (temp_a_reg & temp_b_reg) == ASFC_NIBBLE_ZERO;
         ASFC_OP_SKE: eval_skip = temp_a_reg == temp_b_reg;
         ASFC_OP_SKNE: eval_skip = temp_a_reg != temp_b_reg;
         ASFC_OP_SKGE: eval_skip = temp_a_reg >= temp_b_reg;
         ASFC_OP_SKLT: eval_skip = temp_a_reg < temp_b_reg;
         ASFC_OP_ROTATE: alu_val = {psw_reg[ASFC_CARRY_BIT], temp_a_reg[3:1]};
         ASFC_OP_ADD, ASFC_OP_ADDC, ASFC_OP_SUB, ASFC_OP_SUBC: alu_val = arith_val;
      endcase
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------

   // Next flags from the executing instruction.
   always_comb begin
      psw_next = psw_reg;
      if (is_arith) begin
         psw_next[ASFC_CARRY_BIT] = arith_cy;
         if (arith_val != ASFC_NIBBLE_ZERO) begin
            psw_next[ASFC_ZERO_BIT] = 1'b0;
         end else if (!psw_reg[ASFC_CMP_BIT]) begin
            psw_next[ASFC_ZERO_BIT] = 1'b1;
         end
      end else if (op_reg == ASFC_OP_ROTATE) begin
         psw_next[ASFC_CARRY_BIT] = temp_a_reg[0];
      end else if (op_reg == ASFC_OP_SKT || op_reg == ASFC_OP_SKF) begin
         psw_next[ASFC_CMP_BIT] = 1'b0;
      end
   end

   // One storage for ALU and status word; an executing instruction wins.
   // A bus write that lands in the busy cycle is lost, so software must not
   // race the sequencer on the status word.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psw_reg <= ASFC_PSW_RESET;
      end else if (pend_reg) begin
         psw_reg <= psw_next;
      end else if (dp_write_reg && dp_addr_reg == ASFC_PSW_OFFSET) begin
         psw_reg <= hwdata[3:0];
      end
   end

   // -----------------------------------------------------------------
   // Write-back and skip
   // -----------------------------------------------------------------

   // Results and strobes registered in the cycle after the operand latch.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= 1'b0;
         result_reg <= ASFC_NIBBLE_ZERO;
         reg_wr_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         skip_reg <= 1'b0;
      end else begin
         done_reg <= pend_reg;
         reg_wr_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         skip_reg <= 1'b0;
         if (pend_reg) begin
            result_reg <= alu_val;
            skip_reg <= eval_skip;
            if (op_reg == ASFC_OP_ROTATE) begin
               reg_wr_reg <= 1'b1;
            end else if (is_arith && psw_reg[ASFC_CMP_BIT]) begin
               reg_wr_reg <= 1'b0;
            end else if (is_arith || op_reg == ASFC_OP_OR ||
                         op_reg == ASFC_OP_AND || op_reg == ASFC_OP_XOR) begin
               reg_wr_reg <= dest_reg;
               mem_wr_reg <= ~dest_reg;
            end
         end
      end
   end

   // Outputs.
   assign busy = pend_reg;
   assign done = done_reg;
   assign result = result_reg;
   assign reg_write = reg_wr_reg;
   assign mem_write = mem_wr_reg;
   assign skip_next = skip_reg;
   assign zero_flag = psw_reg[ASFC_ZERO_BIT];
   assign carry_flag = psw_reg[ASFC_CARRY_BIT];
   assign compare_no_store_flag = psw_reg[ASFC_CMP_BIT];
   assign decimal_flag = psw_reg[ASFC_DEC_BIT];

endmodule : asfc_alu

`default_nettype wire

// ===== asfc_alu_assertions.sv
// Checker for the status flag block: latency, store and flag relations.
// Assumes one clock hclk and the asynchronous active-low reset hresetn.
`timescale 1ns/1ns
`default_nettype none

module asfc_alu_chk
   import asfc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic exec,
   input wire asfc_op_type op,
   input wire logic dest_is_reg,
   input wire logic [3:0] first_operand,
   input wire logic [3:0] second_operand,
   input wire logic busy,
   input wire logic done,
   input wire logic [3:0] result,
   input wire logic reg_write,
   input wire logic mem_write,
   input wire logic skip_next,
   input wire logic zero_flag,
   input wire logic carry_flag,
   input wire logic compare_no_store_flag
);
   asfc_op_type op_reg;
   logic [3:0] a_reg, b_reg;
   logic d_reg, arith;

   // Keeps the instruction that was taken, for judging it at done.
   always_ff @(posedge hclk) begin
      if (exec && !busy) begin
         op_reg <= op;
         a_reg <= first_operand;
         b_reg <= second_operand;
         d_reg <= dest_is_reg;
      end
   end
   assign arith = (op_reg <= ASFC_OP_SUBC);

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_done_latency: assert property (exec && !busy |=> busy ##1 (done && !busy))
      else $error("done not two edges after exec");
   // Store, flag and skip behaviour judged at the done pulse.
   a_cmp_no_store: assert property (
      done && arith && $past(compare_no_store_flag) |-> !reg_write && !mem_write)
      else $error("arithmetic stored with compare flag set");
   a_zero_set: assert property (
      done && arith && !$past(compare_no_store_flag) |-> zero_flag == (result == 4'h0))
      else $error("zero flag does not follow result");
   a_zero_hold: assert property (
      done && arith && $past(compare_no_store_flag) && zero_flag |-> $past(zero_flag))
      else $error("zero flag rose with compare flag set");
   a_carry_kept: assert property (
      done && !arith && op_reg != ASFC_OP_ROTATE |-> $stable(carry_flag) && $stable(zero_flag))
      else $error("flags changed by a non-arithmetic instruction");
   a_rotate_shape: assert property (
      done && op_reg == ASFC_OP_ROTATE
      |-> result == {$past(carry_flag), a_reg[3:1]} && carry_flag == a_reg[0] && reg_write)
      else $error("rotation through carry wrong");
   a_eval_clears: assert property (
      done && op_reg inside {ASFC_OP_SKT, ASFC_OP_SKF}
      |-> !compare_no_store_flag && !reg_write && !mem_write)
      else $error("bit evaluation left compare flag or stored");
   a_logic_stores: assert property (
      done && op_reg == ASFC_OP_AND
      |-> result == (a_reg & b_reg) && reg_write == d_reg && mem_write == !d_reg)
      else $error("logical result or store wrong");
   a_skip_equal: assert property (done && op_reg == ASFC_OP_SKE |-> skip_next == (a_reg == b_reg))
      else $error("equal compare skip wrong");

   c_store: cover property (done && reg_write);
   c_skip: cover property (done && skip_next);
   c_no_store: cover property (done && arith && $past(compare_no_store_flag));
endmodule : asfc_alu_chk

bind asfc_alu asfc_alu_chk i_asfc_alu_chk (.hclk(hclk), .hresetn(hresetn), .exec(exec), .op(op),
   .dest_is_reg(dest_is_reg), .first_operand(first_operand), .second_operand(second_operand),
   .busy(busy), .done(done), .result(result), .reg_write(reg_write), .mem_write(mem_write),
   .skip_next(skip_next), .zero_flag(zero_flag), .carry_flag(carry_flag),
   .compare_no_store_flag(compare_no_store_flag));

`default_nettype wire

// ===== asfc_alu_tb_top.sv
// Self-checking bench for the status flag block.
// Assumes zero wait-state AHB-Lite and a 100 MHz hclk.
`timescale 1ns/1ns
`default_nettype none

module asfc_alu_tb_top
   import asfc_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, exec, dest_is_reg, hreadyout, hresp, busy, done;
   logic reg_write, mem_write, skip_next, zero_flag, carry_flag, compare_no_store_flag, decimal_flag;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [3:0] first_operand, second_operand, result, gen_reg, mem_word;
   asfc_op_type op;
   int err_total, checked;

   asfc_alu i_asfc_alu (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .exec(exec), .op(op), .dest_is_reg(dest_is_reg),
      .first_operand(first_operand), .second_operand(second_operand), .busy(busy), .done(done),
      .result(result), .reg_write(reg_write), .mem_write(mem_write), .skip_next(skip_next),
      .zero_flag(zero_flag), .carry_flag(carry_flag), .compare_no_store_flag(compare_no_store_flag),
      .decimal_flag(decimal_flag));
   asfc_store_model i_asfc_store_model (.hclk(hclk), .hresetn(hresetn), .reg_write(reg_write),
      .mem_write(mem_write), .result(result), .gen_reg(gen_reg), .mem_word(mem_word));

   // Counts a comparison and reports a difference.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One single AHB-Lite transfer; the address phase holds until hready.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] v, input logic [31:0] exp);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {28'h000_0000, v};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      if (!wr) check(hrdata, exp);
      check(hresp, 1'b0);
   endtask : bus

   // Issues one instruction and judges its outcome at done.
   task automatic run(input asfc_op_type o, input logic [3:0] a, input logic [3:0] b, input logic d,
         input logic [3:0] res, input logic [1:0] st, input logic sk, input logic [3:0] fl);
      @(posedge hclk);
      op <= o;
      first_operand <= a;
      second_operand <= b;
      dest_is_reg <= d;
      exec <= 1'b1;
      @(posedge hclk);
      exec <= 1'b0;
      for (int i = 0; i < 4 && done !== 1'b1; i++) begin
         @(posedge hclk);
         #1;
      end
      check(done, 1'b1);
      check({reg_write, mem_write}, st);
      check(skip_next, sk);
      check({decimal_flag, compare_no_store_flag, carry_flag, zero_flag}, fl);
      if (o < ASFC_OP_OR || st != 2'h0) check(result, res);
      if (st != 2'h0) begin
         @(posedge hclk);
         #1;
         check(st[1] ? gen_reg : mem_word, res);
      end
   endtask : run

   // Binary arithmetic with carry, borrow and zero.
   task automatic t_binary;
      run(ASFC_OP_ADD, 4'h7, 4'h9, 1'b1, 4'h0, 2'h2, 1'b0, 4'h3);
      run(ASFC_OP_ADDC, 4'h2, 4'h3, 1'b0, 4'h6, 2'h1, 1'b0, 4'h0);
      run(ASFC_OP_SUB, 4'h3, 4'h5, 1'b1, 4'he, 2'h2, 1'b0, 4'h2);
      run(ASFC_OP_SUBC, 4'h5, 4'h4, 1'b1, 4'h0, 2'h2, 1'b0, 4'h1);
   endtask : t_binary

   // Compare flag suppresses stores and holds zero; bit test clears it.
   task automatic t_compare;
      bus(1'b1, ASFC_PSW_OFFSET, 4'h5, 0);
      run(ASFC_OP_SUB, 4'h5, 4'h5, 1'b1, 4'h0, 2'h0, 1'b0, 4'h5);
      run(ASFC_OP_ADD, 4'h1, 4'h2, 1'b0, 4'h3, 2'h0, 1'b0, 4'h4);
      run(ASFC_OP_SKT, 4'h7, 4'h6, 1'b1, 4'h0, 2'h0, 1'b1, 4'h0);
   endtask : t_compare

   // Logic, rotation and evaluations ignore both mode flags.
   task automatic t_modes;
      bus(1'b1, ASFC_PSW_OFFSET, 4'he, 0);
      run(ASFC_OP_OR, 4'h5, 4'ha, 1'b1, 4'hf, 2'h2, 1'b0, 4'he);
      run(ASFC_OP_AND, 4'h6, 4'h3, 1'b0, 4'h2, 2'h1, 1'b0, 4'he);
      run(ASFC_OP_ROTATE, 4'h6, 4'h0, 1'b0, 4'hb, 2'h2, 1'b0, 4'hc);
      run(ASFC_OP_XOR, 4'h6, 4'h3, 1'b1, 4'h5, 2'h2, 1'b0, 4'hc);
      run(ASFC_OP_SKGE, 4'h3, 4'h9, 1'b0, 4'h0, 2'h0, 1'b0, 4'hc);
      run(ASFC_OP_SKLT, 4'h3, 4'h9, 1'b0, 4'h0, 2'h0, 1'b1, 4'hc);
      run(ASFC_OP_SKE, 4'h4, 4'h4, 1'b0, 4'h0, 2'h0, 1'b1, 4'hc);
      run(ASFC_OP_SKNE, 4'h4, 4'h4, 1'b0, 4'h0, 2'h0, 1'b0, 4'hc);
      run(ASFC_OP_SKF, 4'h5, 4'ha, 1'b0, 4'h0, 2'h0, 1'b1, 4'h8);
   endtask : t_modes

   // Single-digit decimal arithmetic including the out-of-range codes.
   task automatic t_decimal;
      run(ASFC_OP_ADD, 4'h9, 4'h9, 1'b1, 4'h8, 2'h2, 1'b0, 4'ha);
      run(ASFC_OP_ADD, 4'ha, 4'ha, 1'b1, 4'he, 2'h2, 1'b0, 4'ha);
      run(ASFC_OP_ADD, 4'h9, 4'h1, 1'b0, 4'h0, 2'h1, 1'b0, 4'hb);
      run(ASFC_OP_SUB, 4'h2, 4'h5, 1'b1, 4'h7, 2'h2, 1'b0, 4'ha);
      run(ASFC_OP_SUBC, 4'h9, 4'h0, 1'b1, 4'h8, 2'h2, 1'b0, 4'h8);
      run(ASFC_OP_ADD, 4'he, 4'he, 1'b1, 4'ha, 2'h2, 1'b0, 4'ha);
      run(ASFC_OP_SUB, 4'h0, 4'hc, 1'b1, 4'he, 2'h2, 1'b0, 4'ha);
      run(ASFC_OP_SUB, 4'hf, 4'h0, 1'b1, 4'hd, 2'h2, 1'b0, 4'ha);
   endtask : t_decimal

   // Status word and temporary registers seen over the bus.
   task automatic t_regs;
      bus(1'b0, ASFC_TEMP_OFFSET, 0, 32'h0000_000f);
      bus(1'b0, ASFC_PSW_OFFSET, 0, 32'h0000_000a);
      bus(1'b1, 8'h08, 4'h5, 0);
      bus(1'b0, 8'h10, 0, 32'h0000_0000);
      bus(1'b0, ASFC_PSW_OFFSET, 0, 32'h0000_000a);
   endtask : t_regs

   // Prints the verdict and ends the run.
   task automatic summarize;
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   // Clock, watchdog and the main sequence.
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      {hresetn, hsel, hwrite, exec, dest_is_reg, haddr, hwdata, htrans} = '0;
      {first_operand, second_operand} = '0;
      op = ASFC_OP_ADD;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, ASFC_PSW_OFFSET, 0, 32'h0000_0000);
      t_binary();
      t_compare();
      t_modes();
      bus(1'b1, ASFC_PSW_OFFSET, 4'h8, 0);
      t_decimal();
      t_regs();
      summarize();
   end
endmodule : asfc_alu_tb_top

`default_nettype wire

// ===== asfc_pkg.sv
// Package for the ALU status flag control block: register map, flag layout,
// reset values and instruction classes.
// Assumes a 32-bit AHB-Lite register bus and a 4-bit data path.
package asfc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ASFC_PSW_OFFSET = 8'h00;
   localparam logic [7:0] ASFC_TEMP_OFFSET = 8'h04;
   localparam int ASFC_ADDR_BITS = 8;

   // -----------------------------------------------------------------
   // Flag field positions within the status word, and temp B position in the temporary register word
   // -----------------------------------------------------------------
   localparam int ASFC_ZERO_BIT = 0;
   localparam int ASFC_CARRY_BIT = 1;
   localparam int ASFC_CMP_BIT = 2;
   localparam int ASFC_DEC_BIT = 3;
   localparam int ASFC_TEMP_B_LSB = 4;

   // -----------------------------------------------------------------
   // Reset values and constants
   // -----------------------------------------------------------------
   localparam logic [3:0] ASFC_PSW_RESET = 4'h0;
   localparam logic [3:0] ASFC_NIBBLE_ZERO = 4'h0;
   localparam logic [5:0] ASFC_BCD_TEN = 6'h0a;
   localparam logic [5:0] ASFC_BCD_TWENTY = 6'h14;
   localparam logic [5:0] ASFC_BCD_SUB_LOW = 6'h36;
   localparam logic [5:0] ASFC_BCD_TWO = 6'h02;
   localparam logic [5:0] ASFC_BCD_28 = 6'h1c;
   localparam logic [5:0] ASFC_BCD_29 = 6'h1d;
   localparam logic [1:0] ASFC_HI_TOP = 2'h3;
   localparam logic [1:0] ASFC_HI_MID = 2'h2;

   // -----------------------------------------------------------------
   // Instruction classes
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      ASFC_OP_ADD, ASFC_OP_ADDC, ASFC_OP_SUB, ASFC_OP_SUBC,
      ASFC_OP_OR, ASFC_OP_AND, ASFC_OP_XOR,
      ASFC_OP_SKT, ASFC_OP_SKF,
      ASFC_OP_SKE, ASFC_OP_SKNE, ASFC_OP_SKGE, ASFC_OP_SKLT,
      ASFC_OP_ROTATE
   } asfc_op_type;

endpackage : asfc_pkg

// ===== asfc_store_model.sv
// Model of the general register and data memory behind the write-back strobes.
// Assumes strobes last one hclk cycle.
`timescale 1ns/1ns
`default_nettype none

module asfc_store_model
   import asfc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic reg_write,
   input wire logic mem_write,
   input wire logic [3:0] result,
   output logic [3:0] gen_reg,
   output logic [3:0] mem_word
);
   // Stores the result where the strobes point.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gen_reg <= ASFC_NIBBLE_ZERO;
         mem_word <= ASFC_NIBBLE_ZERO;
      end else begin
         if (reg_write) begin
            gen_reg <= result;
         end
         if (mem_write) begin
            mem_word <= result;
         end
      end
   end
endmodule : asfc_store_model

`default_nettype wire
